// ---- afe_windowed_watchdog_tb.sv ----
`timescale 1ns/100ps
`define CHECK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module afe_windowed_watchdog_tb;
	import afw_pkg::*;
	logic clk = 0, rst = 1, ce = 1, low_power = 0, osc_run = 0;
	logic slow_osc, mcu_reset, afe_reset, wake, same;
	logic [2:0] div = 3'h0;
	afw_bridge_req_t req;
	afw_status_t st;
	int errors = 0, tests_run = 0, n, m;
	always #4 clk = ~clk;
	// slow oscillator, 8 clocks a period, frozen when not running
	always @(posedge clk) begin
		#1;
		if (osc_run) div = div + 3'h1;
	end
	assign slow_osc = div[2];
	afw_mcu_model mcu (.clk(clk), .req(req));
	afw_windowed_watchdog uut (.clk(clk), .rst(rst), .ce(ce),
		.slow_osc(slow_osc), .bridge_req(req), .low_power(low_power),
		.status(st), .mcu_reset(mcu_reset), .afe_reset(afe_reset),
		.wake(wake));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic results;
		$display("tests %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// counts pulse length and watches both reset outputs agree
	task automatic pulse_len;
		n = 0;
		same = 1'b1;
		while (mcu_reset === 1'b1 && n < 300) begin
			if (afe_reset !== mcu_reset) same = 1'b0;
			n++;
			step(1);
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_premature;
		`CHECK(st.reload, RELOAD_RST)
		`CHECK(st.window, WINDOW_RST)
		`CHECK(st.wake_sel, WAKE_SEL_RST)
		`CHECK(st.wd_en, 1'b0)
		`CHECK(st.countdown_counter, RELOAD_RST)
		`CHECK(mcu_reset, 1'b0)
		mcu.cmd(OP_SET_RELOAD, 16'h0020);
		mcu.cmd(OP_SET_WINDOW, 16'h0004);
		mcu.cmd(OP_ENABLE, 16'h0001);
		// an unused op code must leave every setting alone
		mcu.cmd(3'h7, 16'h0000);
		mcu.cmd(OP_REFRESH, 16'h0000);
		`CHECK(mcu_reset, 1'b1)
		pulse_len();
		`CHECK(n, RST_PULSE_CYC)
		`CHECK(same, 1'b1)
		step(1);
		`CHECK(st.wd_reset_flag, 1'b1)
		`CHECK(st.reload, 16'h0020)
		`CHECK(st.window, 16'h0004)
		`CHECK(st.wd_en, 1'b1)
		`CHECK(st.countdown_counter, 16'h0020)
		$display("test premature refresh done");
	endtask
	task automatic t_expiry;
		mcu.cmd(OP_CLR_FLAG, 16'h0000);
		step(50);
		`CHECK(st.wd_reset_flag, 1'b0)
		// no slow ticks: counter must not move on the fast clock
		`CHECK(st.countdown_counter, 16'h0020)
		osc_run = 1'b1;
		n = 0;
		while (mcu_reset !== 1'b1 && n < 400) begin
			n++;
			step(1);
		end
		`CHECK(n inside {[240:270]}, 1'b1)
		step(2);
		`CHECK(st.wd_reset_flag, 1'b1)
		step(130);
		$display("test expiry done");
	endtask
	task automatic t_window;
		n = 0;
		while (st.countdown_counter > 16'h0004 && n < 400) begin
			n++;
			step(1);
		end
		mcu.cmd(OP_REFRESH, 16'h0000);
		step(1);
		`CHECK(mcu_reset, 1'b0)
		`CHECK(st.countdown_counter > 16'h0004, 1'b1)
		// a looping refresher lands above the window at once
		mcu.cmd(OP_REFRESH, 16'h0000);
		`CHECK(mcu_reset, 1'b1)
		// requests during the reset pulse must be dropped
		mcu.cmd(OP_CLR_FLAG, 16'h0000);
		mcu.cmd(OP_ENABLE, 16'h0000);
		step(130);
		`CHECK(mcu_reset, 1'b0)
		`CHECK(st.wd_reset_flag, 1'b1)
		`CHECK(st.wd_en, 1'b1)
		$display("test window refresh done");
	endtask
	task automatic t_freeze;
		logic [15:0] v;
		v = st.countdown_counter;
		ce = 1'b0;
		step(40);
		ce = 1'b1;
		step(1);
		// a tick may land on the edge just before the freeze
		same = (st.countdown_counter === v)
			|| (st.countdown_counter === v - 16'h0001);
		`CHECK(same, 1'b1)
		step(40);
		`CHECK(st.countdown_counter < v - 16'h0001, 1'b1)
		$display("test clock enable done");
	endtask
	task automatic t_wake;
		mcu.cmd(OP_ENABLE, 16'h0000);
		for (int s = 6; s >= 0; s--) begin
			mcu.cmd(OP_SET_WAKE, 16'h0008 | 16'(s));
			step(1);
			`CHECK(st.wake_sel, 3'(s))
		end
		low_power = 1'b1;
		n = 0;
		while (wake !== 1'b1 && n < 34000) begin
			n++;
			step(1);
		end
		`CHECK(wake, 1'b1)
		m = 0;
		do begin
			step(1);
			m++;
		end while (wake !== 1'b1 && m < 40000);
		`CHECK(m, 4096 * 8)
		low_power = 1'b0;
		$display("test wake timer done");
	endtask
	// ----------------------------------------
	// sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		step(1);
		t_premature();
		t_expiry();
		t_window();
		t_freeze();
		t_wake();
		results();
	end
	initial begin
		#(8 * 100000);
		errors++;
		results();
	end
endmodule

// ---- afw_mcu_model.sv ----
`timescale 1ns/100ps
module afw_mcu_model
	import afw_pkg::*;
(
	input wire logic clk,
	output afw_pkg::afw_bridge_req_t req
);
	initial req = '0;
	// ----------------------------------------
	// bridge commands
	// ----------------------------------------
	// one-cycle pulse; data flips on release so stale words never pass
	task automatic cmd(input logic [2:0] op, input logic [15:0] d);
		@(posedge clk);
		#1;
		req = '{valid: 1'b1, op: op, data: d};
		@(posedge clk);
		#1;
		req.valid = 1'b0;
		req.data = ~d;
	endtask
endmodule

// ---- afw_pkg.sv ----
// Summary of operation
// - software access only through bridge port
// - missed refresh resets whole device
// - wake periods 125 ms up to 8 s
// - wake timer runs, wakes repeatedly while asleep
// - watchdog counts slow oscillator ticks only
// - watchdog reset sets reset source flag
// - reset reaches microcontroller and front end
// - refresh above window counts as premature
// - flag and config survive watchdog reset
package afw_pkg;

	// ----------------------------------------------------------
	// timing
	// ----------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned SLOW_OSC_HZ = 32768;
	localparam int unsigned WAKE_BASE_MS = 125;
	localparam int unsigned WAKE_BASE_TICKS =
		SLOW_OSC_HZ * WAKE_BASE_MS / 1000;
	localparam int unsigned WAKE_SEL_MAX = 6;
	localparam int unsigned RST_PULSE_NS = 1000;
	localparam int unsigned RST_PULSE_CYC =
		(RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------
	// widths and reset values
	// ----------------------------------------------------------
	localparam int unsigned CNT_W = 16;
	localparam int unsigned WAKE_W = 19;
	localparam int unsigned HOLD_W = 8;
	localparam logic [15:0] RELOAD_RST = 16'h8000;
	localparam logic [15:0] WINDOW_RST = 16'h4000;
	localparam logic [2:0] WAKE_SEL_RST = 3'h3;
	localparam logic [HOLD_W-1:0] HOLD_LAST =
		HOLD_W'(RST_PULSE_CYC - 1);

	// ----------------------------------------------------------
	// bridge commands
	// ----------------------------------------------------------
	localparam logic [2:0] OP_REFRESH = 3'h0;
	localparam logic [2:0] OP_SET_RELOAD = 3'h1;
	localparam logic [2:0] OP_SET_WINDOW = 3'h2;
	localparam logic [2:0] OP_SET_WAKE = 3'h3;
	localparam logic [2:0] OP_CLR_FLAG = 3'h4;
	localparam logic [2:0] OP_ENABLE = 3'h5;
	localparam int unsigned WAKE_EN_BIT = 3;
	localparam int unsigned WD_EN_BIT = 0;

	typedef struct packed {
		logic valid;
		logic [2:0] op;
		logic [15:0] data;
	} afw_bridge_req_t;

	typedef struct packed {
		logic [15:0] countdown_counter;
		logic [15:0] window;
		logic [15:0] reload;
		logic [2:0] wake_sel;
		logic wake_en;
		logic wd_en;
		logic wd_reset_flag;
	} afw_status_t;

	typedef enum logic {
		ST_RUN,
		ST_FIRE
	} afw_state_t;

endpackage

// ---- afw_wake_timer.sv ----
`timescale 1ns/100ps
module afw_wake_timer
	import afw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic slow_tick,
	input wire logic enable,
	input wire logic low_power,
	input wire logic [2:0] sel,
	output logic wake
);
	import afw_pkg::*;

	logic [WAKE_W-1:0] cnt;
	logic [WAKE_W-1:0] limit;
	logic [2:0] sel_c;

	// ----------------------------------------------------------
	// period select
	// ----------------------------------------------------------
	// codes above 8 s clamp rather than wrap to a tiny period
	always_comb begin
		sel_c = (sel > 3'(WAKE_SEL_MAX)) ? 3'(WAKE_SEL_MAX) : sel;
		limit = WAKE_W'(WAKE_BASE_TICKS) << sel_c;
	end

	// ----------------------------------------------------------
	// tick counter
	// ----------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= '0;
			wake <= 1'b0;
		end else if (ce) begin
			wake <= 1'b0;
			if (!enable || !low_power) begin
				cnt <= '0;
			end else if (slow_tick) begin
				if (cnt >= limit - WAKE_W'(1)) begin
					cnt <= '0;
					wake <= 1'b1;
				end else begin
					cnt <= cnt + WAKE_W'(1);
				end
			end
		end
	end

	wake_only_asleep_a: assert property (
		@(posedge clk) disable iff (rst)
		$rose(wake) |-> $past(low_power) && $past(enable)
	) else $error("wake pulse outside low power");

	wake_on_tick_a: assert property (
		@(posedge clk) disable iff (rst)
		wake |-> $past(slow_tick) && $past(cnt) == limit - WAKE_W'(1)
	) else $error("wake not at end of period");

endmodule

// ---- afw_windowed_watchdog.sv ----
`timescale 1ns/100ps
module afw_windowed_watchdog
	import afw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic slow_osc,
	input afw_pkg::afw_bridge_req_t bridge_req,
	input wire logic low_power,
	output afw_pkg::afw_status_t status,
	output logic mcu_reset,
	output logic afe_reset,
	output logic wake
);
	import afw_pkg::*;

	logic sync1;
	logic sync2;
	logic sync3;
	logic slow_level;
	logic slow_tick;
	logic [CNT_W-1:0] countdown_counter;
	logic [CNT_W-1:0] reload;
	logic [CNT_W-1:0] window;
	logic [2:0] wake_sel;
	logic wake_en;
	logic wd_en;
	logic wd_reset_flag;
	logic wd_reset;
	logic [HOLD_W-1:0] hold;
	afw_state_t state;
	logic req_ok;
	logic refresh;
	logic premature;
	logic expire;
	logic fire;
	logic [HOLD_W-1:0] fire_age;

	// ----------------------------------------------------------
	// slow oscillator sampling
	// ----------------------------------------------------------
	// the counter never sees the fast reference clock, only these ticks
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else if (ce) begin
			sync1 <= slow_osc;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			slow_level <= 1'b0;
			slow_tick <= 1'b0;
		end else if (ce) begin
			slow_tick <= 1'b0;
			if (sync2 == sync3 && sync3 != slow_level) begin
				slow_level <= sync3;
				slow_tick <= sync3;
			end
		end
	end

	// ----------------------------------------------------------
	// bridge decode
	// ----------------------------------------------------------
	// requests are dropped while the reset pulse is out
	always_comb begin
		req_ok = bridge_req.valid && state == ST_RUN;
		refresh = req_ok && bridge_req.op == OP_REFRESH;
		premature = refresh && wd_en && countdown_counter > window;
		expire = wd_en && slow_tick && countdown_counter <= CNT_W'(1);
		fire = state == ST_RUN && (premature || expire);
	end

	// configuration keeps its value across a watchdog reset
	always_ff @(posedge clk) begin
		if (rst) begin
			reload <= RELOAD_RST;
			window <= WINDOW_RST;
			wake_sel <= WAKE_SEL_RST;
			wake_en <= 1'b0;
			wd_en <= 1'b0;
		end else if (ce && req_ok) begin
			case (bridge_req.op)
				OP_SET_RELOAD: reload <= bridge_req.data;
				OP_SET_WINDOW: window <= bridge_req.data;
				OP_SET_WAKE: begin
					wake_sel <= bridge_req.data[2:0];
					wake_en <= bridge_req.data[WAKE_EN_BIT];
				end
				OP_ENABLE: wd_en <= bridge_req.data[WD_EN_BIT];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------
	// countdown and reset sequencing
	// ----------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_RUN;
			countdown_counter <= RELOAD_RST;
			hold <= '0;
			wd_reset <= 1'b0;
		end else if (ce) begin
			case (state)
				ST_RUN: begin
					if (fire) begin
						state <= ST_FIRE;
						hold <= HOLD_LAST;
						wd_reset <= 1'b1;
						countdown_counter <= reload;
					end else if (refresh || !wd_en) begin
						countdown_counter <= reload;
					end else if (slow_tick) begin
						countdown_counter <= countdown_counter - CNT_W'(1);
					end
				end
				ST_FIRE: begin
					if (hold == '0) begin
						state <= ST_RUN;
						wd_reset <= 1'b0;
					end else begin
						hold <= hold - HOLD_W'(1);
					end
				end
				default: begin
					state <= ST_RUN;
					wd_reset <= 1'b0;
				end
			endcase
		end
	end

	// set beats a clear arriving in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			wd_reset_flag <= 1'b0;
		end else if (ce) begin
			if (fire) begin
				wd_reset_flag <= 1'b1;
			end else if (req_ok && bridge_req.op == OP_CLR_FLAG) begin
				wd_reset_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------
	// outputs
	// ----------------------------------------------------------
	always_comb begin
		mcu_reset = wd_reset;
		afe_reset = wd_reset;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			status <= '0;
		end else if (ce) begin
			status.countdown_counter <= countdown_counter;
			status.window <= window;
			status.reload <= reload;
			status.wake_sel <= wake_sel;
			status.wake_en <= wake_en;
			status.wd_en <= wd_en;
			status.wd_reset_flag <= wd_reset_flag;
		end
	end

	afw_wake_timer u_wake (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.slow_tick(slow_tick),
		.enable(wake_en),
		.low_power(low_power),
		.sel(wake_sel),
		.wake(wake)
	);

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			fire_age <= '0;
		end else if (ce) begin
			fire_age <= wd_reset ? fire_age + HOLD_W'(1) : '0;
		end
	end

	premature_fire_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && state == ST_RUN && refresh && wd_en
			&& countdown_counter > window
		|=> wd_reset && wd_reset_flag
	) else $error("premature refresh did not reset");

	expiry_fire_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && state == ST_RUN && wd_en && slow_tick
			&& countdown_counter == CNT_W'(1)
		|=> mcu_reset && afe_reset
	) else $error("expiry did not reset");

	refresh_reload_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && state == ST_RUN && refresh && wd_en
			&& countdown_counter <= window && !expire
		|=> countdown_counter == $past(reload) && !wd_reset
	) else $error("in-window refresh did not reload");

	tick_only_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && state == ST_RUN && wd_en && !slow_tick && !refresh
		|=> countdown_counter == $past(countdown_counter)
	) else $error("counter moved without slow tick");

	pulse_len_a: assert property (
		@(posedge clk) disable iff (rst)
		$fell(wd_reset) |-> $past(fire_age) == HOLD_W'(RST_PULSE_CYC - 1)
	) else $error("reset pulse length wrong");

	flag_kept_a: assert property (
		@(posedge clk) disable iff (rst)
		$fell(wd_reset) |-> wd_reset_flag || $past(req_ok)
	) else $error("reset flag lost by watchdog reset");

	flag_set_a: assert property (
		@(posedge clk) disable iff (rst)
		$rose(wd_reset) |-> wd_reset_flag ##2 status.wd_reset_flag
	) else $error("flag not set with reset");

	config_keep_a: assert property (
		@(posedge clk) disable iff (rst)
		wd_reset |=> reload == $past(reload) && window == $past(window)
	) else $error("config changed during reset");

	bridge_ignore_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && state == ST_FIRE && bridge_req.valid
		|=> wd_en == $past(wd_en) && wake_sel == $past(wake_sel)
			&& wd_reset_flag
	) else $error("bridge request taken during reset");

endmodule
